// ===== include/act_pkg.sv
// What this block does
// RL1: Gain stage starts unipolar; bit 7 of control B selects bipolar mode.
// RL2: Unipolar result saturates to full scale when negative input is not below positive.
// RL3: Unipolar result is 10-bit unsigned; bipolar is 9 bits plus sign.
// RL4: Left adjust bit 4 aligns result left in data pair, else right.
// RL5: Left adjust change alters data pair presentation at once, even mid-conversion.
// RL6: Reserved bits 5 and 3 of control B read back as last written.
// RL7: Trigger source field only acts while auto trigger enable is set.
// RL8: Auto conversion starts on rising edge of selected flag, not its level.
// RL9: Switching from a clear source to a set source is a rising edge.
// RL10: Switching to free running never makes a trigger event by itself.
// RL11: Sources 0..4: free running, comparator, ext irq 0, t0 match A, t0 overflow.
// RL12: Sources 5..7: t1 match B, t1 overflow, t1 capture.
// RL13: Each disable bit turns off the digital input buffer of its pin.
// RL14: A disabled pin reads as zero in the port input register.
// RL15: Software should disable buffers of analog pins whose digital value is unused.
// RL16: Done flag sets at conversion end; cleared by vector ack or writing one.
// RL17: Auto trigger enable lets selected trigger edges start conversions.
// RL18: Edges found by comparing selected flag with its value one cycle before.
package act_pkg;

  localparam int          ACT_ADDR_W     = 4;
  localparam int          ACT_DATA_W     = 8;
  localparam int          ACT_RESULT_W   = 10;
  localparam int          ACT_PAD_W      = ACT_DATA_W - (ACT_RESULT_W - ACT_DATA_W);
  localparam int          ACT_SRC_W      = 3;
  localparam int          ACT_PIN_COUNT  = 8;
  localparam int          ACT_INT_W      = 2;

  // Register addresses
  localparam logic [3:0]  ACT_ADDR_CTRL_A   = 4'h0;
  localparam logic [3:0]  ACT_ADDR_PIN_OFF  = 4'h1;
  localparam logic [3:0]  ACT_ADDR_CTRL_B   = 4'h2;
  localparam logic [3:0]  ACT_ADDR_DATA_LO  = 4'h4;
  localparam logic [3:0]  ACT_ADDR_DATA_HI  = 4'h5;
  localparam logic [3:0]  ACT_ADDR_INT_STAT = 4'h8;
  localparam logic [3:0]  ACT_ADDR_INT_CLR  = 4'h9;
  localparam logic [3:0]  ACT_ADDR_INT_EN   = 4'ha;

  // Control A fields
  localparam int          ACT_A_ENABLE   = 7;
  localparam int          ACT_A_START    = 6;
  localparam int          ACT_A_AUTO     = 5;
  localparam int          ACT_A_DONE     = 4;

  // Control B fields
  localparam int          ACT_B_BIPOLAR  = 7;
  localparam int          ACT_B_CMP_MUX  = 6;
  localparam int          ACT_B_RSV_HI   = 5;
  localparam int          ACT_B_LEFT     = 4;
  localparam int          ACT_B_RSV_LO   = 3;

  // Interrupt status bits
  localparam int          ACT_INT_DONE   = 0;
  localparam int          ACT_INT_MISSED = 1;

  localparam logic [7:0]  ACT_RESET_BYTE = 8'h00;
  localparam logic [9:0]  ACT_FULL_SCALE = 10'h3ff;

  // Trigger source codes [RL11] [RL12]
  typedef enum logic [2:0] {
    ACT_SRC_FREE_RUN  = 3'h0,
    ACT_SRC_COMP      = 3'h1,
    ACT_SRC_EXT_IRQ0  = 3'h2,
    ACT_SRC_T0_CMP_A  = 3'h3,
    ACT_SRC_T0_OVF    = 3'h4,
    ACT_SRC_T1_CMP_B  = 3'h5,
    ACT_SRC_T1_OVF    = 3'h6,
    ACT_SRC_T1_CAPT   = 3'h7
  } act_src_t;

endpackage : act_pkg

// ===== src/act_adc_ctrl_b.sv
`timescale 1ns/1ps
`default_nettype none

module act_adc_ctrl_b
  import act_pkg::*;
#(
  parameter int PIN_COUNT = ACT_PIN_COUNT
) (
  // Clock and reset
  input  wire logic                        i_sys_clk,
  input  wire logic                        i_arst_n,
  // Register port
  input  wire logic [ACT_ADDR_W-1:0]       i_addr,
  input  wire logic [ACT_DATA_W-1:0]       i_wr_data,
  input  wire logic                        i_wr_stb,
  input  wire logic                        i_rd_stb,
  output logic      [ACT_DATA_W-1:0]       o_rd_data,
  // Trigger flags, indexed by source code; entry 0 unused
  input  wire logic [ACT_DATA_W-1:0]       i_trigger_flags,
  input  wire logic                        i_vector_ack,
  // Converter core
  output logic                             o_conv_start,
  output logic                             o_conv_abort,
  output logic                             o_conv_busy,
  input  wire logic                        i_conv_done,
  input  wire logic signed [ACT_RESULT_W:0] i_sample_diff,
  output logic                             o_bipolar_mode,
  output logic                             o_comparator_mux_enable,
  // Analog pins
  output logic      [PIN_COUNT-1:0]        o_pin_buffer_off,
  input  wire logic [PIN_COUNT-1:0]        i_pin_raw,
  output logic      [PIN_COUNT-1:0]        o_pin_read,
  // Interrupt
  output logic                             o_irq
);

  if (PIN_COUNT < 1 || PIN_COUNT > ACT_DATA_W) begin : g_bad_pins
    $error("PIN_COUNT must fit one register byte");
  end

  logic [ACT_DATA_W-1:0]   ctrl_b;
  logic [PIN_COUNT-1:0]    pin_off;
  logic                    conv_enable;
  logic                    auto_trig_en;
  logic                    busy;
  logic                    done_flag;
  logic [ACT_RESULT_W-1:0] result;
  logic                    prev_sel;
  logic [ACT_SRC_W-1:0]    prev_src;
  logic [ACT_INT_W-1:0]    int_status;
  logic [ACT_INT_W-1:0]    int_enable;

  logic                    wr_a;
  logic                    wr_b;
  logic                    wr_pins;
  logic                    wr_iclr;
  logic                    wr_ien;
  logic                    en_now;
  logic                    sw_start;
  logic                    sel_flag;
  logic                    trig_edge;
  logic                    trig_start;
  logic                    conv_start;
  logic                    done_set;
  logic                    done_clr;
  logic                    left_adj;
  logic [ACT_SRC_W-1:0]    src;
  logic [ACT_RESULT_W-1:0] next_result;
  logic [ACT_INT_W-1:0]    int_set;
  logic [ACT_DATA_W-1:0]   next_rd_data;

  assign wr_a     = i_wr_stb && (i_addr == ACT_ADDR_CTRL_A);
  assign wr_b     = i_wr_stb && (i_addr == ACT_ADDR_CTRL_B);
  assign wr_pins  = i_wr_stb && (i_addr == ACT_ADDR_PIN_OFF);
  assign wr_iclr  = i_wr_stb && (i_addr == ACT_ADDR_INT_CLR);
  assign wr_ien   = i_wr_stb && (i_addr == ACT_ADDR_INT_EN);
  assign src      = ctrl_b[ACT_SRC_W-1:0];
  assign left_adj = ctrl_b[ACT_B_LEFT];

  // Control B: every bit stored, reserved ones included
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_b <= ACT_RESET_BYTE;
    end else if (wr_b) begin
      ctrl_b <= i_wr_data; // [RL1] [RL6]
    end
  end

  assign o_bipolar_mode          = ctrl_b[ACT_B_BIPOLAR]; // [RL1]
  assign o_comparator_mux_enable = ctrl_b[ACT_B_CMP_MUX];

  // Digital input disable
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pin_off <= '0;
    end else if (wr_pins) begin
      pin_off <= i_wr_data[PIN_COUNT-1:0];
    end
  end

  assign o_pin_buffer_off = pin_off; // [RL13]

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pin_read <= '0;
    end else begin
      o_pin_read <= i_pin_raw & ~pin_off; // [RL14]
    end
  end

  // Control A enables
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      conv_enable  <= 1'b0;
      auto_trig_en <= 1'b0;
    end else if (wr_a) begin
      conv_enable  <= i_wr_data[ACT_A_ENABLE];
      auto_trig_en <= i_wr_data[ACT_A_AUTO]; // [RL17]
    end
  end

  // Enable written together with start counts as enabled
  assign en_now   = wr_a ? i_wr_data[ACT_A_ENABLE] : conv_enable;
  assign sw_start = wr_a && i_wr_data[ACT_A_START] && i_wr_data[ACT_A_ENABLE];

  // Free running watches the done flag itself
  assign sel_flag = (src == ACT_SRC_FREE_RUN) ? done_flag : i_trigger_flags[src]; // [RL11] [RL12]

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      prev_sel <= 1'b0;
      prev_src <= ACT_SRC_FREE_RUN;
    end else begin
      prev_sel <= sel_flag; // [RL18]
      prev_src <= src;
    end
  end

  // Source switch counts as an edge, except into free running
  assign trig_edge  = sel_flag && !prev_sel // [RL8] [RL9] [RL18]
                      && !((src == ACT_SRC_FREE_RUN) && (prev_src != ACT_SRC_FREE_RUN)); // [RL10]
  assign trig_start = en_now && auto_trig_en && trig_edge; // [RL7] [RL17]
  assign conv_start = (sw_start || trig_start) && !busy;

  // Clearing enable kills a running conversion
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      busy <= 1'b0;
    end else if (!en_now) begin
      busy <= 1'b0;
    end else if (conv_start) begin
      busy <= 1'b1;
    end else if (i_conv_done) begin
      busy <= 1'b0;
    end
  end

  assign o_conv_busy = busy;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_conv_start <= 1'b0;
      o_conv_abort <= 1'b0;
    end else begin
      o_conv_start <= conv_start;
      o_conv_abort <= busy && !en_now;
    end
  end

  // Result formatting
  always_comb begin
    if (o_bipolar_mode) begin
      next_result = i_sample_diff[ACT_RESULT_W:1]; // [RL3]
    end else if (i_sample_diff <= 0) begin
      next_result = ACT_FULL_SCALE; // [RL2]
    end else begin
      next_result = i_sample_diff[ACT_RESULT_W-1:0]; // [RL3]
    end
  end

  assign done_set = busy && en_now && i_conv_done;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      result <= '0;
    end else if (done_set) begin
      result <= next_result;
    end
  end

  // Done flag: a completion beats a clear in the same cycle
  assign done_clr = (wr_a && i_wr_data[ACT_A_DONE]) || i_vector_ack;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      done_flag <= 1'b0;
    end else if (done_set) begin
      done_flag <= 1'b1; // [RL16]
    end else if (done_clr) begin
      done_flag <= 1'b0; // [RL16]
    end
  end

  // Interrupt status: done, and triggers lost while busy
  assign int_set[ACT_INT_DONE]   = done_set;
  assign int_set[ACT_INT_MISSED] = trig_start && busy;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      int_status <= '0;
    end else begin
      int_status <= int_set | (int_status & ~(wr_iclr ? i_wr_data[ACT_INT_W-1:0] : '0));
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      int_enable <= '0;
    end else if (wr_ien) begin
      int_enable <= i_wr_data[ACT_INT_W-1:0];
    end
  end

  assign o_irq = |(int_status & int_enable);

  // Read mux; data pair alignment follows the live left adjust bit
  always_comb begin
    next_rd_data = '0;
    case (i_addr)
      ACT_ADDR_CTRL_A: begin
        next_rd_data[ACT_A_ENABLE] = conv_enable;
        next_rd_data[ACT_A_START]  = busy;
        next_rd_data[ACT_A_AUTO]   = auto_trig_en;
        next_rd_data[ACT_A_DONE]   = done_flag;
      end
      ACT_ADDR_PIN_OFF: begin
        next_rd_data[PIN_COUNT-1:0] = pin_off;
      end
      ACT_ADDR_CTRL_B: begin
        next_rd_data = ctrl_b; // [RL6]
      end
      ACT_ADDR_DATA_LO: begin
        next_rd_data = left_adj ? {result[ACT_RESULT_W-ACT_DATA_W-1:0], {ACT_PAD_W{1'b0}}} // [RL4] [RL5]
                                : result[ACT_DATA_W-1:0];
      end
      ACT_ADDR_DATA_HI: begin
        next_rd_data = left_adj ? result[ACT_RESULT_W-1:ACT_RESULT_W-ACT_DATA_W] // [RL4] [RL5]
                                : {{ACT_PAD_W{1'b0}}, result[ACT_RESULT_W-1:ACT_DATA_W]};
      end
      ACT_ADDR_INT_STAT: begin
        next_rd_data[ACT_INT_W-1:0] = int_status;
      end
      ACT_ADDR_INT_EN: begin
        next_rd_data[ACT_INT_W-1:0] = int_enable;
      end
      default: begin
        next_rd_data = '0;
      end
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_rd_data <= '0;
    end else if (i_rd_stb) begin
      o_rd_data <= next_rd_data;
    end else begin
      o_rd_data <= '0;
    end
  end

  // Checks

  bipolar_select_a: assert property ( // [RL1]
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    wr_b |=> o_bipolar_mode == $past(i_wr_data[ACT_B_BIPOLAR]))
    else $error("bipolar mode does not follow control write");

  unipolar_clamp_a: assert property ( // [RL2]
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    done_set && !o_bipolar_mode && (i_sample_diff <= 0) |=> result == ACT_FULL_SCALE)
    else $error("unipolar result not clamped to full scale");

  bipolar_result_a: assert property ( // [RL3]
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    done_set && o_bipolar_mode |=> result == $past(i_sample_diff[ACT_RESULT_W:1]))
    else $error("bipolar result not two's complement of difference");

  left_adjust_a: assert property ( // [RL4] [RL5]
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    i_rd_stb && (i_addr == ACT_ADDR_DATA_HI) && left_adj && !done_set
      |=> o_rd_data == result[ACT_RESULT_W-1:ACT_RESULT_W-ACT_DATA_W])
    else $error("left adjusted high byte wrong");

  reserved_back_a: assert property ( // [RL6]
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    wr_b ##1 (i_rd_stb && (i_addr == ACT_ADDR_CTRL_B) && !wr_b)
      |=> (o_rd_data[ACT_B_RSV_HI] == $past(i_wr_data[ACT_B_RSV_HI], 2))
          && (o_rd_data[ACT_B_RSV_LO] == $past(i_wr_data[ACT_B_RSV_LO], 2)))
    else $error("reserved bits not read back");

  no_auto_start_a: assert property ( // [RL7]
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    !auto_trig_en && !sw_start |=> !o_conv_start)
    else $error("start with auto trigger disabled");

  edge_start_a: assert property ( // [RL8] [RL9] [RL18]
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    conv_enable && auto_trig_en && !wr_a && !busy && sel_flag && !prev_sel
      && (src != ACT_SRC_FREE_RUN) |=> o_conv_start)
    else $error("rising trigger flag did not start conversion");

  level_no_start_a: assert property ( // [RL8]
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    sel_flag && prev_sel && !sw_start |=> !o_conv_start)
    else $error("conversion started on flag level");

  free_switch_a: assert property ( // [RL10]
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    (src == ACT_SRC_FREE_RUN) && (prev_src != ACT_SRC_FREE_RUN) && !sw_start |=> !o_conv_start)
    else $error("switch to free running caused a trigger");

  pin_masked_a: assert property ( // [RL14]
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    1'b1 |=> (o_pin_read & $past(pin_off)) == '0)
    else $error("disabled pin reads nonzero");

  done_flag_a: assert property ( // [RL16]
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    (done_set |=> done_flag) and (done_clr && !done_set |=> !done_flag))
    else $error("done flag set or clear wrong");

  no_start_off_a: assert property ( // [RL17]
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    !en_now |=> !o_conv_start)
    else $error("start while converter disabled");

  unipolar_result_a: assert property ( // [RL3]
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    done_set && !o_bipolar_mode && (i_sample_diff > 0) |=> result == $past(i_sample_diff[ACT_RESULT_W-1:0]))
    else $error("unipolar result not the plain difference");

  right_adjust_a: assert property ( // [RL4] [RL5]
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    i_rd_stb && (i_addr == ACT_ADDR_DATA_LO) && !left_adj && !done_set
      |=> o_rd_data == result[ACT_DATA_W-1:0])
    else $error("right adjusted low byte wrong");

  left_low_a: assert property ( // [RL4] [RL5]
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    i_rd_stb && (i_addr == ACT_ADDR_DATA_LO) && left_adj && !done_set
      |=> o_rd_data == {result[ACT_RESULT_W-ACT_DATA_W-1:0], {ACT_PAD_W{1'b0}}})
    else $error("left adjusted low byte wrong");

  result_hold_a: assert property ( // [RL16]
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    !done_set |=> $stable(result))
    else $error("result changed without a completion");

  done_idle_a: assert property ( // [RL16]
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    !busy && !done_flag |=> !done_flag)
    else $error("done flag set without a conversion");

  pin_buffer_a: assert property ( // [RL13]
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    wr_pins |=> o_pin_buffer_off == $past(i_wr_data[PIN_COUNT-1:0]))
    else $error("pin buffer disable does not follow write");

  free_retrigger_a: assert property ( // [RL11]
    @(posedge i_sys_clk) disable iff (!i_arst_n)
    conv_enable && auto_trig_en && !wr_a && !busy && done_flag && !prev_sel
      && (src == ACT_SRC_FREE_RUN) && (prev_src == ACT_SRC_FREE_RUN) |=> o_conv_start)
    else $error("free running did not restart on done flag");

endmodule : act_adc_ctrl_b

`default_nettype wire

// ===== testbench/act_far_model.sv
`timescale 1ns/1ps
`default_nettype none

module act_far_model
  import act_pkg::*;
#(
  parameter int CONV_CYCLES = 3
) (
  // Clock and reset
  input  wire logic                         i_sys_clk,
  input  wire logic                         i_arst_n,
  // Converter core side
  input  wire logic                         i_conv_start,
  input  wire logic signed [ACT_RESULT_W:0] i_diff_val,
  output logic                              o_conv_done,
  output logic signed [ACT_RESULT_W:0]      o_sample_diff
);
  int cnt;

  // Sample valid only beside done; inverted elsewhere so a stale capture shows
  assign o_sample_diff = o_conv_done ? i_diff_val : ~i_diff_val;

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt         <= 0;
      o_conv_done <= 1'b0;
    end else begin
      o_conv_done <= (cnt == 1);
      if (i_conv_start) begin
        cnt <= CONV_CYCLES;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule : act_far_model

`default_nettype wire

// ===== testbench/act_adc_ctrl_b_tb.sv
`timescale 1ns/1ps
`default_nettype none

module act_adc_ctrl_b_tb
  import act_pkg::*;
;
  logic clk, rst_n, wr_stb, rd_stb, ack, rd_d, done;
  logic [3:0] addr;
  logic [7:0] wdata, flags, raw, rdat, boff, pread, off, cb;
  logic signed [10:0] diff, sdiff, d;
  logic start, abort, busy, bip, cmux, irq, b, l;
  logic [9:0] r;
  logic [7:0] exp_q[$];
  int num_errors, total_checks, starts, cyc, s;

  act_adc_ctrl_b act_adc_ctrl_b_inst (.i_sys_clk(clk), .i_arst_n(rst_n), .i_addr(addr), .i_wr_data(wdata),
    .i_wr_stb(wr_stb), .i_rd_stb(rd_stb), .o_rd_data(rdat), .i_trigger_flags(flags), .i_vector_ack(ack),
    .o_conv_start(start), .o_conv_abort(abort), .o_conv_busy(busy), .i_conv_done(done),
    .i_sample_diff(sdiff), .o_bipolar_mode(bip), .o_comparator_mux_enable(cmux),
    .o_pin_buffer_off(boff), .i_pin_raw(raw), .o_pin_read(pread), .o_irq(irq));

  act_far_model act_far_model_inst (.i_sys_clk(clk), .i_arst_n(rst_n), .i_conv_start(start),
    .i_diff_val(diff), .o_conv_done(done), .o_sample_diff(sdiff));

  always #10 clk = ~clk;

  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr   <= a;
    wdata  <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr

  // Expectation noted by the driver, compared by the monitor below
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    exp_q.push_back(e);
    addr   <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
  endtask : rd

  task automatic conv_wait;
    int n;
    repeat (3) @(negedge clk);
    for (n = 0; n < 40 && busy !== 1'b0; n++) @(negedge clk);
    @(negedge clk);
  endtask : conv_wait

  function automatic logic [9:0] exp_res(input logic signed [10:0] v, input logic bp);
    if (bp) return v[10:1];
    return (v <= 0) ? ACT_FULL_SCALE : v[9:0];
  endfunction : exp_res

  always @(posedge clk) begin
    rd_d <= rd_stb;
    if (start === 1'b1) starts++;
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end

  always @(negedge clk) begin
    if (rd_d === 1'b1) chk("rd_data", exp_q.pop_front(), rdat);
  end

  initial begin
    clk = 0; rst_n = 0; wr_stb = 0; rd_stb = 0; ack = 0; addr = 0; wdata = 0;
    flags = 0; raw = 0; diff = 0; rd_d = 0;
    void'($urandom(32'h9dfe));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(ACT_ADDR_CTRL_B, 8'h00);
    rd(ACT_ADDR_PIN_OFF, 8'h00);
    wr(4'hf, 8'hff);
    rd(4'hf, 8'h00);
    off = 8'($urandom);
    wr(ACT_ADDR_PIN_OFF, off);
    @(posedge clk);
    raw <= 8'($urandom);
    repeat (2) @(negedge clk);
    chk("pin_read", raw & ~off, pread);
    chk("buffer_off", off, boff);
    rd(ACT_ADDR_PIN_OFF, off);
    // Enable with auto trigger; every hardware source once
    wr(ACT_ADDR_CTRL_A, 8'ha0);
    for (s = 1; s < 8; s++) begin
      b  = s[0];
      l  = s[1];
      cb = {b, 1'($urandom), 1'($urandom), l, 1'($urandom), 3'(s)};
      d  = (s == 2) ? 11'sh0 : 11'($urandom);
      diff <= d;
      wr(ACT_ADDR_CTRL_B, cb);
      rd(ACT_ADDR_CTRL_B, cb);
      chk("bipolar", b, bip);
      chk("cmux", cb[6], cmux);
      @(posedge clk);
      flags <= 8'h01 << s;
      conv_wait();
      chk("starts", s, starts);
      r = exp_res(d, b);
      rd(ACT_ADDR_DATA_HI, l ? r[9:2] : {6'h0, r[9:8]});
      rd(ACT_ADDR_DATA_LO, l ? {r[1:0], 6'h0} : r[7:0]);
      wr(ACT_ADDR_CTRL_B, cb ^ 8'h10);
      rd(ACT_ADDR_DATA_HI, l ? {6'h0, r[9:8]} : r[9:2]);
      @(posedge clk);
      flags <= 8'h00;
    end
    rd(ACT_ADDR_CTRL_A, 8'hb0);
    rd(ACT_ADDR_INT_STAT, 8'h01);
    wr(ACT_ADDR_INT_EN, 8'h01);
    @(negedge clk);
    chk("irq", 1, irq);
    wr(ACT_ADDR_INT_CLR, 8'h01);
    @(negedge clk);
    chk("irq", 0, irq);
    wr(ACT_ADDR_CTRL_A, 8'hb0);
    rd(ACT_ADDR_CTRL_A, 8'ha0);
    // Selected flag low, other flag high, then switch over
    @(posedge clk);
    flags <= 8'h08;
    repeat (4) @(negedge clk);
    chk("starts", 7, starts);
    wr(ACT_ADDR_CTRL_B, 8'h03);
    conv_wait();
    chk("starts", 8, starts);
    repeat (10) @(negedge clk);
    chk("starts", 8, starts);
    wr(ACT_ADDR_CTRL_B, 8'h00);
    repeat (6) @(negedge clk);
    chk("starts", 8, starts);
    chk("irq", 1, irq);
    @(posedge clk);
    ack <= 1'b1;
    @(posedge clk);
    ack <= 1'b0;
    rd(ACT_ADDR_CTRL_A, 8'ha0);
    wr(ACT_ADDR_CTRL_A, 8'h80);
    wr(ACT_ADDR_CTRL_B, 8'h05);
    @(posedge clk);
    flags <= 8'h20;
    repeat (6) @(negedge clk);
    chk("starts", 8, starts);
    // Free running: one software start, then the done flag's own rise restarts once
    wr(ACT_ADDR_CTRL_B, 8'h00);
    wr(ACT_ADDR_CTRL_A, 8'he0);
    repeat (8) @(negedge clk);
    chk("starts", 10, starts);
    chk("busy", 1, busy);
    wr(ACT_ADDR_CTRL_A, 8'h00);
    @(negedge clk);
    chk("abort", 1, abort);
    chk("busy", 0, busy);
    repeat (6) @(negedge clk);
    chk("starts", 10, starts);
    chk("abort", 0, abort);
    repeat (3) @(negedge clk);
    give_verdict();
  end
endmodule : act_adc_ctrl_b_tb

`default_nettype wire
